// [dv/msdc_prog_model.sv]
// Programmer and receiver model: shared pin, selection and reply decoding.
`timescale 1ns/1ps
`default_nettype none
module msdc_prog_model
	import msdc_pkg::*;
(
	// Clock.
	input  wire logic   clk_sys_i,
	// Wire parties.
	input  wire logic   out_oe_i,
	input  wire logic   sel_i,
	output logic        pin_o,
	// Decoded word.
	output logic        word_valid_o = 1'b0,
	output logic [15:0] word_o = 16'h0000
);
	logic        prev_r = 1'b1;
	logic        half_r = 1'b0;
	logic [4:0]  cnt_r  = 5'h00;
	logic [15:0] sh_r   = 16'h0000;
	logic [15:0] gap_r  = 16'h0000;

	// Pulled-up wire; the programmer selects the sensor by pulling it low.
	assign pin_o = !(out_oe_i || sel_i);

	// Gap decoder; a very long or very short gap restarts the word, so stray edges
	// from measurement or selection cannot shift bits in.
	always_ff @(posedge clk_sys_i) begin
		prev_r <= pin_o;
		word_valid_o <= 1'b0;
		gap_r <= (gap_r == 16'hffff) ? gap_r : gap_r + 16'h0001;
		if (pin_o != prev_r) begin
			gap_r <= 16'h0001;
			if (gap_r > BIT_CYC * 3 / 2 || gap_r < 16'h012c) begin
				cnt_r <= 5'h00;
				half_r <= 1'b0;
			end else if (!half_r && gap_r < 16'h0384) begin
				half_r <= 1'b1;
			end else begin
				half_r <= 1'b0;
				sh_r <= {sh_r[14:0], half_r};
				cnt_r <= cnt_r + 5'h01;
				if (cnt_r == 5'h0f) begin
					word_valid_o <= 1'b1;
					word_o <= {sh_r[14:0], half_r};
				end
			end
		end
	end
endmodule
`default_nettype wire

// [dv/msdc_props.sv]
// Port checker for the field sensor top level.
`timescale 1ns/1ps
`default_nettype none
module msdc_props
	import msdc_pkg::*;
(
	// Clock, reset and commands.
	input wire logic       clk_sys_i,
	input wire logic       rst_i,
	input wire logic       power_up_i,
	input wire logic       cmd_busy_i,
	input wire logic       cmd_valid_i,
	input wire logic       cmd_write_i,
	input wire logic [5:0] cmd_addr_i,
	input wire logic       out_pin_i,
	// Outputs under watch.
	input wire logic       out_o,
	input wire logic       out_oe_o,
	input wire logic [2:0] range_sel_o,
	input wire logic [7:0] range_mt_o,
	input wire logic       lock_active_o
);
	// Full scale in millitesla for each range code.
	localparam logic [7:0] MT [8] = '{8'h1e, 8'h4b, 8'h5a, 8'h96, 8'h28, 8'h3c, 8'h50, 8'h64};
	logic wr_mode;

	// A write aimed at the mode word.
	assign wr_mode = cmd_valid_i && cmd_write_i && cmd_addr_i == ADDR_MODE;

	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);

	rst_val_a: assert property ($fell(rst_i) |-> !out_oe_o && !lock_active_o && range_sel_o == 3'h0)
		else $error("Outputs not at reset state.");
	od_data_a: assert property (out_o == 1'b0)
		else $error("Open-drain data not low.");
	range_map_a: assert property ($stable(range_sel_o) |-> range_mt_o == MT[range_sel_o])
		else $error("Range scale mismatch.");
	lock_keep_a: assert property (lock_active_o |=> lock_active_o)
		else $error("Lock was cleared.");
	lock_rise_a: assert property ($rose(lock_active_o) |-> $past(power_up_i, 2))
		else $error("Lock rose without power-up.");
	lock_refuse_a: assert property (lock_active_o && wr_mode |=> $stable(range_sel_o) [*3])
		else $error("Locked write took effect.");
	unsel_a: assert property (out_pin_i [*3] ##0 wr_mode |=> $stable(range_sel_o) [*3])
		else $error("Unselected write took effect.");
	reply_go_a: assert property ((!out_pin_i [*3] ##0 (cmd_valid_i && !lock_active_o && !out_oe_o))
		|-> ##[3:4] out_oe_o)
		else $error("Reply did not start.");
	busy_off_a: assert property (cmd_busy_i [*4] |-> !out_oe_o)
		else $error("Output driven during telegram.");
endmodule
`default_nettype wire

// [dv/tb_top.sv]
// Top-level bench of the field sensor chain and its programming reply.
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import msdc_pkg::*;
;
	localparam int          LIMIT = 100000;
	localparam logic [15:0] TRIM  = 16'h3c96; // Arbitrary value.
	localparam logic [7:0]  MT [8] = '{8'h1e, 8'h4b, 8'h5a, 8'h96, 8'h28, 8'h3c, 8'h50, 8'h64};
	logic        clk_sys_i   = 1'b0;
	logic        rst_i       = 1'b1;
	logic        power_up_i  = 1'b0;
	logic        sample_valid_i = 1'b0;
	logic        cmd_busy_i  = 1'b0;
	logic        cmd_valid_i = 1'b0;
	logic        cmd_write_i = 1'b0;
	logic [5:0]  cmd_addr_i  = 6'h00;
	logic [15:0] cmd_wdata_i = 16'h0000;
	logic        sel         = 1'b0;
	logic        pin;
	logic        out_o;
	logic        out_oe_o;
	logic [2:0]  range_sel_o;
	logic [7:0]  range_mt_o;
	logic        lock_active_o;
	logic        wv;
	logic [15:0] word;
	int          bad_count   = 0;
	int          checked     = 0;
	int          cycles      = 0;

	// ****************************************************************
	// Clock, design and far side
	// ****************************************************************
	always #20 clk_sys_i = ~clk_sys_i;

	msdc_top #(.P_PWM_MIN_CYC(64), .P_TRIM(TRIM)) dut (
		.clk_sys_i, .rst_i, .power_up_i,
		.sample_valid_i, .sample_i(16'h0000), .temp_i(8'h19),
		.cmd_busy_i, .cmd_valid_i, .cmd_write_i, .cmd_addr_i, .cmd_wdata_i,
		.out_pin_i(pin), .supply_ok_i(1'b1), .out_o, .out_oe_o,
		.range_sel_o, .range_mt_o, .lock_active_o);

	msdc_prog_model prog (.clk_sys_i, .out_oe_i(out_oe_o), .sel_i(sel), .pin_o(pin),
		.word_valid_o(wv), .word_o(word));

	// ****************************************************************
	// Shared tasks
	// ****************************************************************
	task automatic check(input logic [15:0] got, input logic [15:0] exp, input string msg);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %0t %s: got %h exp %h", $time, msg, got, exp);
		end
	endtask

	task automatic results;
		$display("Counts: %0d checked, %0d bad", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic reset_dut;
		rst_i = 1'b1;
		repeat (3) @(negedge clk_sys_i);
		rst_i = 1'b0;
		repeat (3) @(negedge clk_sys_i);
	endtask

	// One-cycle command strobe; the pin is released the cycle after it is taken.
	task automatic issue(input logic w, input logic [5:0] a, input logic [15:0] d);
		cmd_write_i = w;
		cmd_addr_i = a;
		cmd_wdata_i = d;
		cmd_valid_i = 1'b1;
		@(negedge clk_sys_i);
		cmd_valid_i = 1'b0;
		cmd_busy_i = 1'b0;
		sel = 1'b0;
	endtask

	// Write without waiting for the reply; the caller cuts it short by reset.
	task automatic poke(input logic [5:0] a, input logic [15:0] d);
		cmd_busy_i = 1'b1;
		sel = 1'b1;
		repeat (3) @(negedge clk_sys_i);
		issue(1'b1, a, d);
		repeat (5) @(negedge clk_sys_i);
	endtask

	// Full command with telegram phase and decoded reply.
	task automatic xfer(input logic w, input logic [5:0] a, input logic [15:0] d,
		input logic [15:0] exp);
		int n;
		n = 0;
		cmd_busy_i = 1'b1;
		sel = 1'b1;
		repeat (1600) @(negedge clk_sys_i);
		issue(w, a, d);
		while (wv !== 1'b1 && n < 20000) begin
			@(negedge clk_sys_i);
			n++;
		end
		check(word, exp, "reply word");
		repeat (20) @(negedge clk_sys_i);
	endtask

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task automatic t_range;
		for (int i = 0; i < 8; i++) begin
			poke(ADDR_MODE, {13'h0000, 3'(i)});
			check({13'h0000, range_sel_o}, {13'h0000, 3'(i)}, "range code");
			check({8'h00, range_mt_o}, {8'h00, MT[i]}, "range scale");
			reset_dut;
		end
		// With the pin released and not pulled low, a write must be ignored.
		cmd_busy_i = 1'b1;
		repeat (4) @(negedge clk_sys_i);
		issue(1'b1, ADDR_MODE, 16'h0007);
		repeat (5) @(negedge clk_sys_i);
		check({13'h0000, range_sel_o}, 16'h0000, "unselected write");
		$display("t_range done");
	endtask

	// Flat curve at half scale; mode is back at PWM, period code 0 after reset.
	// Zero-field samples keep the processed value at mid scale.
	task automatic t_pwm;
		int n;
		int r;
		logic p;
		n = 0;
		r = 0;
		for (int i = 0; i < 32; i++) begin
			poke(ADDR_CURVE + 6'(i), 16'h0100);
			reset_dut;
		end
		sample_valid_i = 1'b1;
		repeat (8192) @(negedge clk_sys_i);
		p = out_oe_o;
		repeat (16384) begin
			@(negedge clk_sys_i);
			n += int'(out_oe_o === 1'b1);
			r += int'(out_oe_o === 1'b1 && p === 1'b0);
			p = out_oe_o;
		end
		check(16'(n), 16'h2000, "pwm low time");
		check(16'(r), 16'h0002, "pwm periods");
		cmd_busy_i = 1'b1;
		repeat (50) @(negedge clk_sys_i);
		check({15'h0000, out_oe_o}, 16'h0000, "busy release");
		cmd_busy_i = 1'b0;
		$display("t_pwm done");
	endtask

	task automatic t_trim;
		xfer(1'b0, ADDR_TRIM, 16'h0000, TRIM);
		xfer(1'b1, ADDR_TRIM, 16'h1111, REPLY_NAK);
		$display("t_trim done");
	endtask

	task automatic t_lock;
		xfer(1'b1, ADDR_LOCK, 16'h0001, 16'h0001);
		check({15'h0000, lock_active_o}, 16'h0000, "lock early");
		power_up_i = 1'b1;
		@(negedge clk_sys_i);
		power_up_i = 1'b0;
		repeat (2) @(negedge clk_sys_i);
		poke(ADDR_MODE, 16'h0003);
		check({15'h0000, lock_active_o}, 16'h0001, "lock on");
		check({13'h0000, range_sel_o}, 16'h0000, "locked write");
		$display("t_lock done");
	endtask

	// Cycle ceiling against a hung handshake.
	always @(posedge clk_sys_i) begin
		cycles++;
		if (cycles == LIMIT) begin
			bad_count++;
			results();
		end
	end

	// Main sequence.
	initial begin
		repeat (16) @(negedge clk_sys_i);
		rst_i = 1'b0;
		repeat (3) @(negedge clk_sys_i);
		t_range();
		t_pwm();
		t_trim();
		t_lock();
		results();
	end
endmodule

bind msdc_top msdc_props chk (.clk_sys_i, .rst_i, .power_up_i, .cmd_busy_i, .cmd_valid_i,
	.cmd_write_i, .cmd_addr_i, .out_pin_i, .out_o, .out_oe_o, .range_sel_o, .range_mt_o,
	.lock_active_o);
`default_nettype wire

// [rtl/msdc_lpf.sv]
// First-order digital low-pass filter with a selectable corner.
`timescale 1ns/1ps
`default_nettype none
module msdc_lpf
	import msdc_pkg::*;
(
	// Clock and reset.
	input  wire logic               clk_sys_i,
	input  wire logic               rst_i,
	// Sample stream.
	input  wire logic               x_valid_i,
	input  wire logic signed [15:0] x_i,
	input  wire logic        [2:0]  sel_i,
	output logic                    y_valid_o,
	output logic signed [15:0]      y_o
);

	logic signed [23:0] acc_r;
	logic signed [24:0] diff;
	logic        [2:0]  k;

	// Each step of the corner code roughly doubles the bandwidth; codes above 4 stay at 2 kHz.
	always_comb begin
		case (sel_i)
			3'h0:    k = 3'h6;
			3'h1:    k = 3'h5;
			3'h2:    k = 3'h4;
			3'h3:    k = 3'h3;
			default: k = 3'h2;
		endcase
		diff = 25'(signed'({x_i, 8'h00})) - 25'(acc_r);
	end

	// Eight guard bits keep small steps from being lost at the slow corners.
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			acc_r     <= '0;
			y_valid_o <= 1'b0;
		end else begin
			y_valid_o <= x_valid_i;
			if (x_valid_i) begin
				acc_r <= acc_r + 24'(diff >>> k);
			end
		end
	end

	assign y_o = acc_r[23:8];

endmodule
`default_nettype wire

// [rtl/msdc_outenc.sv]
// Output line encoder: PWM or Biphase-M words.
`timescale 1ns/1ps
`default_nettype none
module msdc_outenc
	import msdc_pkg::*;
#(
	parameter int P_PWM_MIN_CYC = PWM_MIN_CYC
) (
	// Clock and reset.
	input  wire logic        clk_sys_i,
	input  wire logic        rst_i,
	// Control.
	input  wire logic        en_i,
	input  wire logic        bpm_i,
	input  wire logic [2:0]  period_sel_i,
	input  wire logic [8:0]  duty_i,
	input  wire logic [15:0] word_i,
	// Line and word handshake.
	output logic             line_o,
	output logic             word_take_o
);

	logic [21:0] cnt_r;
	logic [3:0]  bit_idx_r;
	logic [15:0] sh_r;
	logic        started_r;
	logic [21:0] per;
	logic [30:0] hi_prod;

	// PWM period doubles per code step below 7; the high time scales with a 9-bit duty.
	always_comb begin
		per     = 22'(P_PWM_MIN_CYC) << (3'd7 - period_sel_i);
		hi_prod = 31'(per) * 31'(duty_i);
	end

	// One counter serves both formats; dropping en_i restarts cleanly with a released line.
	always_ff @(posedge clk_sys_i) begin
		if (rst_i || !en_i) begin
			cnt_r       <= '0;
			bit_idx_r   <= '0;
			sh_r        <= '0;
			started_r   <= 1'b0;
			line_o      <= 1'b1;
			word_take_o <= 1'b0;
		end else if (!bpm_i) begin
			word_take_o <= 1'b0;
			cnt_r       <= (cnt_r >= per - 22'd1) ? 22'd0 : cnt_r + 22'd1;
			line_o      <= (cnt_r < hi_prod[30:9]);
		end else if (!started_r) begin
			started_r   <= 1'b1;
			sh_r        <= word_i;
			bit_idx_r   <= '0;
			cnt_r       <= '0;
			word_take_o <= 1'b1;
			line_o      <= ~line_o;
		end else begin
			word_take_o <= 1'b0;
			if (cnt_r == 22'(BIT_CYC - 1)) begin
				cnt_r  <= '0;
				line_o <= ~line_o;
				if (bit_idx_r == 4'hf) begin
					sh_r        <= word_i;
					word_take_o <= 1'b1;
				end else begin
					sh_r <= {sh_r[14:0], 1'b0};
				end
				bit_idx_r <= bit_idx_r + 4'h1;
			end else begin
				cnt_r <= cnt_r + 22'd1;
				if (cnt_r == 22'(BIT_MID_CYC - 1) && sh_r[15]) begin
					line_o <= ~line_o;
				end
			end
		end
	end

endmodule
`default_nettype wire

// [rtl/msdc_pkg.sv]
// Constants, field layouts and types shared by the field sensor signal chain.
// Function
// - Once lock is active, every later write attempt to the configuration is refused.
// - While unlocked, configuration registers, including the transfer curve, accept writes.
// - A valid accepted command performs its read or write, then replies on the pin.
// - The measurement output stays released during any programming communication.
// - With no command activity and supply good, the chosen PWM or Biphase-M runs.
// - Commands are honoured only while this sensor is selected through its pin.
// - Signal processing takes every parameter from the stored configuration registers only.
// - Samples are low-pass filtered, then scaled by gain, temperature terms and offset.
// - Thirty-two equally spaced curve points, linear interpolation between neighbours.
// - Offset gives the zero-field output; the gain factor sets magnetic sensitivity.
// - After locking, the part identifier is delivered only in Biphase-M mode.
// - Factory trim is fixed and read-only to the user.
// - The processed field value is readable, ranging from 0 to 4095.
// - Mode word bits two to zero select the converter field range.
// - Above range: three filter bits, three protocol bits, three period bits on top.
// - Range codes decode to 30,75,90,150,40,60,80,100 millitesla for codes 0 to 7.
// - Filter codes 0 to 4 give 80 Hz, 160 Hz, 500 Hz, 1 kHz, 2 kHz.
// - Protocol 2 is PWM, 4 is Biphase-M after lock, 5 test Biphase-M.
// - PWM period halves from 128 ms at code 0 to 1 ms at code 7.
// - Biphase-M toggles at each bit boundary, and mid-bit for a one only; the encoder makes that toggle at five eighths of the bit.
package msdc_pkg;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int CLK_HZ           = 25_000_000;
	localparam int BIT_TIME_NS      = 40_000;
	localparam int BIT_CYC          = (CLK_HZ / 1_000_000) * BIT_TIME_NS / 1000;
	localparam int BIT_MID_CYC      = (BIT_CYC * 5) / 8;
	localparam int PWM_MIN_PER_US   = 1000;
	localparam int PWM_MIN_CYC      = (CLK_HZ / 1_000_000) * PWM_MIN_PER_US;

	// ****************************************************************
	// Register addresses of the programming interface
	// ****************************************************************
	localparam logic [5:0] ADDR_MODE     = 6'h00;
	localparam logic [5:0] ADDR_SLOPE    = 6'h01;
	localparam logic [5:0] ADDR_SHIFT    = 6'h02;
	localparam logic [5:0] ADDR_TCL      = 6'h03;
	localparam logic [5:0] ADDR_TCQ      = 6'h04;
	localparam logic [5:0] ADDR_PART_ID  = 6'h05;
	localparam logic [5:0] ADDR_LOCK     = 6'h06;
	localparam logic [5:0] ADDR_DIG_OUT  = 6'h07;
	localparam logic [5:0] ADDR_TRIM     = 6'h08;
	localparam logic [5:0] ADDR_CURVE    = 6'h20;

	// ****************************************************************
	// Mode word layout and codes
	// ****************************************************************
	localparam int RANGE_LSB  = 0;
	localparam int FILTER_LSB = 3;
	localparam int FORMAT_LSB = 6;
	localparam int PERIOD_LSB = 9;
	localparam logic [2:0] FMT_PWM      = 3'h2;
	localparam logic [2:0] FMT_BPM      = 3'h4;
	localparam logic [2:0] FMT_BPM_TEST = 3'h5;

	// ****************************************************************
	// Reset values, reply codes and reference temperature
	// ****************************************************************
	localparam logic [11:0] MODE_RST  = 12'h080;
	localparam logic [13:0] SLOPE_RST = 14'h0800;
	localparam logic [15:0] REPLY_NAK = 16'hdead;
	localparam logic [11:0] DIG_MID   = 12'h800;
	localparam logic signed [7:0] TEMP_REF = 8'sh19;

	// Reply sequencer states.
	typedef enum logic [2:0] {
		MSDC_IDLE  = 3'b001,
		MSDC_BUSY  = 3'b010,
		MSDC_REPLY = 3'b100
	} msdc_state_t;

endpackage

// [rtl/msdc_top.sv]
// Field sensor signal chain, configuration store, lock and programming reply.
`timescale 1ns/1ps
`default_nettype none
module msdc_top
	import msdc_pkg::*;
#(
	parameter int          P_PWM_MIN_CYC = PWM_MIN_CYC,
	parameter logic [15:0] P_TRIM        = 16'h5a5a // Arbitrary value.
) (
	// Clock and reset.
	input  wire logic               clk_sys_i,
	input  wire logic               rst_i,
	input  wire logic               power_up_i,
	// Converter samples and die temperature.
	input  wire logic               sample_valid_i,
	input  wire logic signed [15:0] sample_i,
	input  wire logic signed [7:0]  temp_i,
	// Decoded supply-modulation commands.
	input  wire logic               cmd_busy_i,
	input  wire logic               cmd_valid_i,
	input  wire logic               cmd_write_i,
	input  wire logic [5:0]         cmd_addr_i,
	input  wire logic [15:0]        cmd_wdata_i,
	// Pin and supply sense.
	input  wire logic               out_pin_i,
	input  wire logic               supply_ok_i,
	// Open-drain output pin.
	output logic                    out_o,
	output logic                    out_oe_o,
	// Converter setup and status.
	output logic [2:0]              range_sel_o,
	output logic [7:0]              range_mt_o,
	output logic                    lock_active_o
);

	// ****************************************************************
	// Configuration store
	// ****************************************************************
	logic [11:0]        mode_r;
	logic signed [13:0] slope_r;
	logic signed [11:0] shift_r;
	logic signed [9:0]  tcl_r;
	logic signed [7:0]  tcq_r;
	logic [15:0]        part_id_r;
	logic               lock_stored_r;
	logic               lock_active_r;
	logic               test_bpm_r;
	logic [8:0]         curve_r [32];
	logic [11:0]        dig_out_r;

	// Synchronisers for pin and supply sense.
	logic pin_meta_r;
	logic pin_sync_r;
	logic sup_meta_r;
	logic sup_sync_r;

	// Reply sequencing.
	msdc_state_t state_r;
	logic [15:0] reply_r;
	logic        take_seen_r;
	logic        pid_pend_r;

	// Encoder connections.
	logic        enc_line;
	logic        enc_take;
	logic        enc_en;
	logic        enc_bpm;
	logic [15:0] enc_word;
	logic        bpm_on;
	logic        pwm_on;
	logic        meas_en;
	logic        accept;
	logic        wr_ok;
	logic [15:0] rd_data;

	// Mode fields.
	logic [2:0] fmt;
	logic [2:0] per_sel;

	assign fmt     = mode_r[FORMAT_LSB +: 3];
	assign per_sel = mode_r[PERIOD_LSB +: 3];

	// The pin is both output and selection input, so its level is synchronised first.
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			pin_meta_r <= 1'b1;
			pin_sync_r <= 1'b1;
			sup_meta_r <= 1'b0;
			sup_sync_r <= 1'b0;
		end else begin
			pin_meta_r <= out_pin_i;
			pin_sync_r <= pin_meta_r;
			sup_meta_r <= supply_ok_i;
			sup_sync_r <= sup_meta_r;
		end
	end

	// ****************************************************************
	// Command decode
	// ****************************************************************

	// A sensor is selected while the programmer holds its released pin low.
	assign accept = cmd_valid_i && !pin_sync_r && !lock_active_r;
	assign wr_ok  = accept && cmd_write_i && !lock_active_r;

	// Read multiplexer; unmapped addresses read as zero.
	always_comb begin
		rd_data = 16'h0000;
		if (cmd_addr_i[5]) begin
			rd_data = {7'h00, curve_r[cmd_addr_i[4:0]]};
		end else begin
			case (cmd_addr_i)
				ADDR_MODE:    rd_data = {4'h0, mode_r};
				ADDR_SLOPE:   rd_data = 16'(slope_r);
				ADDR_SHIFT:   rd_data = 16'(shift_r);
				ADDR_TCL:     rd_data = 16'(tcl_r);
				ADDR_TCQ:     rd_data = 16'(tcq_r);
				ADDR_PART_ID: rd_data = part_id_r;
				ADDR_LOCK:    rd_data = {15'h0000, lock_stored_r};
				ADDR_DIG_OUT: rd_data = {4'h0, dig_out_r};
				ADDR_TRIM:    rd_data = P_TRIM;
				default:      rd_data = 16'h0000;
			endcase
		end
	end

	// Register writes; trim and the processed value are never writable.
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			mode_r    <= MODE_RST;
			slope_r   <= SLOPE_RST;
			shift_r   <= '0;
			tcl_r     <= '0;
			tcq_r     <= '0;
			part_id_r <= '0;
		end else if (wr_ok && !cmd_addr_i[5]) begin
			case (cmd_addr_i)
				ADDR_MODE:    mode_r    <= cmd_wdata_i[11:0];
				ADDR_SLOPE:   slope_r   <= cmd_wdata_i[13:0];
				ADDR_SHIFT:   shift_r   <= cmd_wdata_i[11:0];
				ADDR_TCL:     tcl_r     <= cmd_wdata_i[9:0];
				ADDR_TCQ:     tcq_r     <= cmd_wdata_i[7:0];
				ADDR_PART_ID: part_id_r <= cmd_wdata_i;
				default:      ;
			endcase
		end
	end

	// Curve points carry no reset value; every point must be written before use.
	always_ff @(posedge clk_sys_i) begin
		if (wr_ok && cmd_addr_i[5]) begin
			curve_r[cmd_addr_i[4:0]] <= cmd_wdata_i[8:0];
		end
	end

	// The lock only takes effect at the next power-up and nothing clears it but full reset.
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			lock_stored_r <= 1'b0;
			lock_active_r <= 1'b0;
		end else begin
			if (wr_ok && cmd_addr_i == ADDR_LOCK && cmd_wdata_i[0]) begin
				lock_stored_r <= 1'b1;
			end
			if (power_up_i && lock_stored_r) begin
				lock_active_r <= 1'b1;
			end
		end
	end

	// Test Biphase-M persists until the next power-up; a write in the power-up cycle still wins.
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			test_bpm_r <= 1'b0;
		end else if (wr_ok && cmd_addr_i == ADDR_MODE
		             && cmd_wdata_i[FORMAT_LSB +: 3] == FMT_BPM_TEST) begin
			test_bpm_r <= 1'b1;
		end else if (power_up_i) begin
			test_bpm_r <= 1'b0;
		end
	end

	// ****************************************************************
	// Signal chain
	// ****************************************************************
	logic               filt_valid;
	logic signed [15:0] filt;
	logic signed [7:0]  dt;
	logic signed [31:0] gain_eff;
	logic signed [31:0] prod;
	logic signed [31:0] sum;
	logic [11:0]        sat;
	logic               proc_valid_r;
	logic [16:0]        pos;
	logic [4:0]         seg;
	logic [11:0]        frac;
	logic signed [9:0]  p_lo;
	logic signed [9:0]  p_hi;
	logic signed [23:0] step;
	logic signed [10:0] interp;
	logic [8:0]         duty_r;

	msdc_lpf u_lpf (
		.clk_sys_i (clk_sys_i),
		.rst_i     (rst_i),
		.x_valid_i (sample_valid_i),
		.x_i       (sample_i),
		.sel_i     (mode_r[FILTER_LSB +: 3]),
		.y_valid_o (filt_valid),
		.y_o       (filt)
	);

	// Sensitivity follows slope plus linear and quadratic temperature terms, then offset.
	always_comb begin
		dt       = temp_i - TEMP_REF;
		gain_eff = 32'(slope_r) + ((32'(tcl_r) * 32'(dt)) >>> 6)
		         + ((32'(tcq_r) * 32'(dt) * 32'(dt)) >>> 10);
		prod     = (32'(filt) * gain_eff) >>> 11;
		sum      = prod + 32'(shift_r) + 32'(DIG_MID);
		if (sum < 32'sd0) begin
			sat = 12'h000;
		end else if (sum > 32'sd4095) begin
			sat = 12'hfff;
		end else begin
			sat = sum[11:0];
		end
	end

	// Processed value register, updated once per filtered sample.
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			dig_out_r    <= DIG_MID;
			proc_valid_r <= 1'b0;
		end else begin
			proc_valid_r <= filt_valid;
			if (filt_valid) begin
				dig_out_r <= sat;
			end
		end
	end

	// Scaling by 31 spreads the 32 points evenly so the top segment never reads past the end.
	always_comb begin
		pos    = 17'(dig_out_r) * 17'd31;
		seg    = pos[16:12];
		frac   = pos[11:0];
		p_lo   = 10'({1'b0, curve_r[seg]});
		p_hi   = 10'({1'b0, curve_r[5'(seg + 5'd1)]});
		step   = (24'(p_hi - p_lo) * 24'(signed'({1'b0, frac}))) >>> 12;
		interp = 11'(p_lo) + 11'(step);
	end

	// Duty register; clamped in case a non-monotonic curve overshoots.
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			duty_r <= '0;
		end else if (proc_valid_r) begin
			if (interp < 11'sd0) begin
				duty_r <= 9'h000;
			end else if (interp > 11'sd511) begin
				duty_r <= 9'h1ff;
			end else begin
				duty_r <= interp[8:0];
			end
		end
	end

	// Converter range code decoded to full scale in millitesla.
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			range_sel_o <= '0;
			range_mt_o  <= 8'd30;
		end else begin
			range_sel_o <= mode_r[RANGE_LSB +: 3];
			case (mode_r[RANGE_LSB +: 3])
				3'h0:    range_mt_o <= 8'd30;
				3'h1:    range_mt_o <= 8'd75;
				3'h2:    range_mt_o <= 8'd90;
				3'h3:    range_mt_o <= 8'd150;
				3'h4:    range_mt_o <= 8'd40;
				3'h5:    range_mt_o <= 8'd60;
				3'h6:    range_mt_o <= 8'd80;
				default: range_mt_o <= 8'd100;
			endcase
		end
	end

	// ****************************************************************
	// Reply sequencer and output selection
	// ****************************************************************

	// The part identifier goes out first after a locked power-up, and only in Biphase-M.
	assign bpm_on  = (fmt == FMT_BPM && lock_active_r)
	               || (fmt == FMT_BPM_TEST && test_bpm_r);
	assign pwm_on  = (fmt == FMT_PWM);
	assign meas_en = (state_r == MSDC_IDLE) && !cmd_busy_i && !cmd_valid_i
	               && sup_sync_r && (pwm_on || bpm_on);
	assign enc_en  = meas_en || (state_r == MSDC_REPLY);
	assign enc_bpm = (state_r == MSDC_REPLY) || bpm_on;
	assign enc_word = (state_r == MSDC_REPLY) ? reply_r
	                : (pid_pend_r ? part_id_r : {4'h0, dig_out_r});

	// The reply is one Biphase-M word; the encoder's second take marks its end.
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			state_r     <= MSDC_IDLE;
			reply_r     <= '0;
			take_seen_r <= 1'b0;
		end else begin
			case (state_r)
				MSDC_IDLE, MSDC_BUSY: begin
					take_seen_r <= 1'b0;
					if (accept) begin
						reply_r <= cmd_write_i ? (wr_ok && cmd_addr_i != ADDR_TRIM
						           && cmd_addr_i != ADDR_DIG_OUT ? cmd_wdata_i
						           : REPLY_NAK) : rd_data;
						state_r <= MSDC_REPLY;
					end else if (cmd_busy_i) begin
						state_r <= MSDC_BUSY;
					end else begin
						state_r <= MSDC_IDLE;
					end
				end
				MSDC_REPLY: begin
					if (enc_take) begin
						take_seen_r <= 1'b1;
						if (take_seen_r) begin
							state_r <= MSDC_IDLE;
						end
					end
				end
				default: state_r <= MSDC_IDLE;
			endcase
		end
	end

	// Identifier request is raised at a power-up with the lock stored or active and dropped once its word is taken.
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			pid_pend_r <= 1'b0;
		end else if (power_up_i && (lock_active_r || lock_stored_r)) begin
			pid_pend_r <= 1'b1;
		end else if (enc_take && state_r != MSDC_REPLY && bpm_on) begin
			pid_pend_r <= 1'b0;
		end
	end

	msdc_outenc #(
		.P_PWM_MIN_CYC (P_PWM_MIN_CYC)
	) u_enc (
		.clk_sys_i    (clk_sys_i),
		.rst_i        (rst_i),
		.en_i         (enc_en),
		.bpm_i        (enc_bpm),
		.period_sel_i (per_sel),
		.duty_i       (duty_r),
		.word_i       (enc_word),
		.line_o       (enc_line),
		.word_take_o  (enc_take)
	);

	// Open drain: a low line level is driven, a high level releases the pin.
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			out_o         <= 1'b0;
			out_oe_o      <= 1'b0;
			lock_active_o <= 1'b0;
		end else begin
			out_o         <= 1'b0;
			out_oe_o      <= enc_en && !enc_line;
			lock_active_o <= lock_active_r;
		end
	end

endmodule
`default_nettype wire
